// file: src/uiso_defines.vh
`ifndef UISO_DEFINES_VH
`define UISO_DEFINES_VH
// bit periods at 50 MHz: full speed 12 Mbps, low speed 1.5 Mbps (rounded down)
`define UISO_CLK_HZ 50000000
`define UISO_FS_BPS 12000000
`define UISO_LS_BPS 1500000
`define UISO_FS_BIT_CYC (`UISO_CLK_HZ / `UISO_FS_BPS)
`define UISO_LS_BIT_CYC (`UISO_CLK_HZ / `UISO_LS_BPS)
`define UISO_LOSS_BITS 32
`define UISO_CNT_W 11
`define UISO_STRAP_EDGE 2'h2
`endif

// file: src/uiso_sync.v
`timescale 1ns/1ps
module uiso_sync #(
  parameter W = 1
) (
  input wire clk_i,
  input wire arst_n_i,
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end
  assign q_o = s2_q;
endmodule // uiso_sync

// file: src/uiso_port_ctrl.v
// Overview of operation
// - the upstream pull-up power follows the upstream pull-up enable input.
// - with pull-up enable low the upstream lines float and the cable sees a disconnect at any speed.
// - downstream speed select high picks full-speed slew, timing and logic; it must be driven definitely.
// - both selects high with both sides powered gives full-speed convention on both ports.
// - both selects low with both sides powered gives low-speed convention on both ports.
// - upstream power loss floats the downstream data drivers within 32 bit times.
// - the downstream side comes up with its data drivers floating.
// - downstream power loss drops the upstream pull-up and data drivers within 32 bit times.
// - upstream speed select high picks full-speed slew, timing and logic; it must be driven definitely.
// - the pull-down strap is sampled on leaving reset; low removes the downstream pull-downs.
`timescale 1ns/1ps
`include "uiso_defines.vh"
module uiso_port_ctrl #(
  parameter LOSS_BITS = `UISO_LOSS_BITS
) (
  input wire clk_i,
  input wire arst_n_i,
  input wire upstream_speed_select_i,
  input wire downstream_speed_select_i,
  input wire upstream_pullup_enable_i,
  input wire pulldown_strap_i,
  input wire side1_powered_i,
  input wire side2_supply_i,
  input wire up_drive_req_i,
  input wire dn_drive_req_i,
  output reg upstream_pullup_on_o,
  output reg upstream_drv_en_o,
  output reg downstream_drv_en_o,
  output reg downstream_pulldown_on_o,
  output reg upstream_full_speed_o,
  output reg downstream_full_speed_o,
  output reg speed_mismatch_o,
  output reg link_active_o
);
  localparam integer FS_INT = `UISO_FS_BIT_CYC;
  localparam integer LS_INT = `UISO_LS_BIT_CYC;
  localparam [`UISO_CNT_W-1:0] FS_CYC = FS_INT[`UISO_CNT_W-1:0];
  localparam [`UISO_CNT_W-1:0] LS_CYC = LS_INT[`UISO_CNT_W-1:0];
  localparam [5:0] LOSS_MAX = LOSS_BITS[5:0];

  wire spu_s;
  wire spd_s;
  wire pin_s;
  wire strap_s;
  wire p1_s;
  wire p2_s;
  uiso_sync #(.W(6)) u_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .d_i({upstream_speed_select_i, downstream_speed_select_i, upstream_pullup_enable_i,
          pulldown_strap_i, side1_powered_i, side2_supply_i}),
    .q_o({spu_s, spd_s, pin_s, strap_s, p1_s, p2_s})
  );

  reg strap_done_q;
  reg strap_q;
  reg [1:0] strap_cnt_q;
  reg [`UISO_CNT_W-1:0] bit_cnt_q;
  reg [5:0] up_loss_q;
  reg [5:0] dn_loss_q;
  reg up_gone_q;
  reg dn_gone_q;
  reg bit_tick;
  reg [`UISO_CNT_W-1:0] bit_len;

  always @* begin
    bit_len = spd_s ? FS_CYC : LS_CYC;
    bit_tick = (bit_cnt_q == bit_len - 1'b1);
  end

  // synchroniser resets low, so wait until it carries the pin level
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
      strap_q <= 1'b1;
    end else if (!strap_done_q) begin
      if (strap_cnt_q == `UISO_STRAP_EDGE) begin
        strap_done_q <= 1'b1;
        strap_q <= strap_s;
      end else begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
    end
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bit_cnt_q <= {`UISO_CNT_W{1'b0}};
    end else if (bit_tick || bit_cnt_q >= bit_len) begin
      bit_cnt_q <= {`UISO_CNT_W{1'b0}};
    end else begin
      bit_cnt_q <= bit_cnt_q + 1'b1;
    end
  end

  // loss counters: sync delay eats two cycles, well within one bit time
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      up_loss_q <= 6'h00;
      dn_loss_q <= 6'h00;
      up_gone_q <= 1'b1;
      dn_gone_q <= 1'b1;
    end else begin
      if (p1_s) begin
        up_loss_q <= 6'h00;
        up_gone_q <= 1'b0;
      end else if (!up_gone_q && bit_tick) begin
        if (up_loss_q >= LOSS_MAX - 6'h02) begin
          up_gone_q <= 1'b1;
        end
        up_loss_q <= up_loss_q + 6'h01;
      end
      if (p2_s) begin
        dn_loss_q <= 6'h00;
        dn_gone_q <= 1'b0;
      end else if (!dn_gone_q && bit_tick) begin
        if (dn_loss_q >= LOSS_MAX - 6'h02) begin
          dn_gone_q <= 1'b1;
        end
        dn_loss_q <= dn_loss_q + 6'h01;
      end
    end
  end

  wire both_up = !up_gone_q && !dn_gone_q;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      upstream_pullup_on_o <= 1'b0;
      upstream_drv_en_o <= 1'b0;
      downstream_drv_en_o <= 1'b0;
      downstream_pulldown_on_o <= 1'b1;
      upstream_full_speed_o <= 1'b0;
      downstream_full_speed_o <= 1'b0;
      speed_mismatch_o <= 1'b0;
      link_active_o <= 1'b0;
    end else begin
      upstream_pullup_on_o <= pin_s && !dn_gone_q;
      upstream_drv_en_o <= pin_s && both_up && up_drive_req_i;
      downstream_drv_en_o <= both_up && strap_done_q && dn_drive_req_i;
      downstream_pulldown_on_o <= strap_q;
      upstream_full_speed_o <= spu_s;
      downstream_full_speed_o <= spd_s;
      speed_mismatch_o <= spu_s ^ spd_s;
      link_active_o <= both_up && pin_s;
    end
  end
endmodule // uiso_port_ctrl

// file: bench/uiso_chk_assertions.sv
`timescale 1ns/1ps
module uiso_chk #(parameter int LOSS_BITS = 32) (
  input wire logic clk_i, arst_n_i, side1_powered_i, side2_supply_i, upstream_speed_select_i,
  input wire logic downstream_speed_select_i, upstream_pullup_enable_i, upstream_pullup_on_o,
  input wire logic upstream_drv_en_o, downstream_drv_en_o, upstream_full_speed_o, downstream_full_speed_o
);
  // low speed bit time is the longer, so it bounds both modes
  localparam int LIM = LOSS_BITS * 33 + 3;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  a_detach_off: assert property (!upstream_pullup_enable_i [*3] |=> !upstream_pullup_on_o)
    else $error("pullup");
  a_dn_full: assert property (downstream_speed_select_i [*3] |=> downstream_full_speed_o)
    else $error("dn fs");
  a_dn_low: assert property (!downstream_speed_select_i [*3] |=> !downstream_full_speed_o)
    else $error("dn ls");
  a_up_full: assert property (upstream_speed_select_i [*3] |=> upstream_full_speed_o)
    else $error("up fs");
  a_up_low: assert property (!upstream_speed_select_i [*3] |=> !upstream_full_speed_o)
    else $error("up ls");
  a_dn_loss: assert property ($fell(side1_powered_i) |-> ##[1:LIM] !downstream_drv_en_o)
    else $error("dn loss");
  a_up_loss: assert property ($fell(side2_supply_i) |-> ##[1:LIM] !upstream_drv_en_o)
    else $error("up loss");
  a_boot_float: assert property (!$past(arst_n_i) |-> !downstream_drv_en_o)
    else $error("boot");
endmodule // uiso_chk

// file: bench/uiso_periph.sv
`timescale 1ns/1ps
module uiso_periph (
  input wire logic clk_i, attach_i, fs_i,
  output logic pu_en_o = 1'b1, spd_o = 1'b0, drv_o = 1'b0
);
  always @(posedge clk_i) begin
    pu_en_o <= attach_i;
    spd_o <= fs_i;
    drv_o <= attach_i;
  end
endmodule // uiso_periph

// file: bench/uiso_port_ctrl_test.sv
`timescale 1ns/1ps
module uiso_port_ctrl_test;
  logic clk_i = 1'b0, rst_n = 1'b0, upstream_speed_select = 1'b0, st = 1'b0, s1 = 1'b1, s2 = 1'b1, upr = 1'b0, at = 1'b1, fs = 1'b0;
  logic pe, downstream_speed_select, dnr, pu, ud, dd, pd, ufs, dfs, mm, la;
  logic [2:0] r;
  integer bad_count = 0, cmp_count = 0, seed = 32'hb5f3294f;
  always #10 clk_i = ~clk_i;
  uiso_periph i_uiso_periph (.clk_i(clk_i), .attach_i(at), .fs_i(fs), .pu_en_o(pe), .spd_o(downstream_speed_select), .drv_o(dnr));
  uiso_port_ctrl #(.LOSS_BITS(4)) i_uiso_port_ctrl (.clk_i(clk_i), .arst_n_i(rst_n), .upstream_speed_select_i(upstream_speed_select),
    .downstream_speed_select_i(downstream_speed_select), .upstream_pullup_enable_i(pe), .pulldown_strap_i(st), .side1_powered_i(s1),
    .side2_supply_i(s2), .up_drive_req_i(upr), .dn_drive_req_i(dnr), .upstream_pullup_on_o(pu),
    .upstream_drv_en_o(ud), .downstream_drv_en_o(dd), .downstream_pulldown_on_o(pd), .upstream_full_speed_o(ufs),
    .downstream_full_speed_o(dfs), .speed_mismatch_o(mm), .link_active_o(la));
  function automatic int loss_cyc(input logic f);
    return 4 * (f ? 4 : 33) + 3; // bit time follows the selected speed
  endfunction
  task automatic chk(input string n, input logic e, input logic s);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    cyc(4);
    rst_n <= 1'b1;
    cyc(1);
    #1 chk("dn_drv", 1'b0, dd);
    for (int k = 0; k < 20; k++) begin
      cyc(1);
      r = 3'($random(seed));
      {fs, upstream_speed_select, at, upr, st} <= {r[0], r[0], r[1], r[2], r[2]};
      cyc(6);
      #1 chk("pullup", at, pu);
      chk("up_drv", upr & at, ud);
      chk("pulldown", 1'b0, pd);
      chk("dn_drv", at, dd);
      chk("up_fs", fs, ufs);
      chk("dn_fs", fs, dfs);
      chk("mismatch", 1'b0, mm);
      chk("active", at, la);
    end
    cyc(1);
    upstream_speed_select <= ~fs;
    cyc(6);
    #1 chk("mismatch", 1'b1, mm);
    chk("up_fs", ~fs, ufs);
    cyc(1);
    upstream_speed_select <= fs;
    for (int f = 0; f < 2; f++) begin
      cyc(1);
      {fs, upstream_speed_select, at, upr, s1} <= {f[0], f[0], 3'h7};
      cyc(6);
      #1 chk("dn_drv", 1'b1, dd);
      cyc(1);
      s1 <= 1'b0;
      cyc(loss_cyc(f[0]));
      #1 chk("dn_drv", 1'b0, dd);
      cyc(1);
      s1 <= 1'b1;
      cyc(6);
      #1 chk("up_side", 1'b1, pu & ud);
      cyc(1);
      s2 <= 1'b0;
      cyc(loss_cyc(f[0]));
      #1 chk("up_side", 1'b0, pu | ud);
      cyc(1);
      s2 <= 1'b1;
    end
    cyc(1);
    {st, rst_n} <= 2'h2;
    cyc(2);
    #1 chk("pulldown", 1'b1, pd);
    chk("dn_drv", 1'b0, dd);
    cyc(1);
    rst_n <= 1'b1;
    cyc(1);
    #1 chk("dn_drv", 1'b0, dd);
    cyc(6);
    #1 chk("pulldown", 1'b1, pd);
    cyc(6);
    tally_and_finish();
  end
  initial begin
    #100us bad_count++;
    tally_and_finish();
  end
endmodule // uiso_port_ctrl_test
bind uiso_port_ctrl uiso_chk #(.LOSS_BITS(LOSS_BITS)) i_uiso_chk (.*);
